// [core/dscr_regs.svh]
// Constants of the serial chain and readback block: reset codes and timing counts.
// Assumes a 200 MHz system clock; included by bare name by the package and the core module.
`ifndef DSCR_REGS_SVH
`define DSCR_REGS_SVH
`define DSCR_WORD_BITS 16
`define DSCR_MIDSCALE 16'h8000
`define DSCR_CLK_PERIOD_PS 5000
`define DSCR_POR_TIME_NS 1000
`define DSCR_FIFO_DEPTH 8
`define DSCR_POR_CNT_BITS 16
`endif

// [core/dscr_pkg.sv]
// Types shared by the serial chain and readback block.
// Assumes dscr_regs.svh supplies the widths.
`include "dscr_regs.svh"
package dscr_pkg;
   typedef logic [`DSCR_WORD_BITS-1:0] dscr_word_t;
   typedef enum logic [1:0] {
      DSCR_FS_IDLE = 2'b01,
      DSCR_FS_SHIFT = 2'b10
   } dscr_frame_t;
endpackage

// [core/dscr_fifo.sv]
// Small flip-flop FIFO with valid and ready on both sides.
// Assumes one clock domain; the depth must be a power of two.
`timescale 1ns/10ps
module dscr_fifo #(
   parameter int W = 17,
   parameter int DEPTH = 8
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic nrst,
   // Filling side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Draining side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } dscr_fifo_st_t;
   dscr_fifo_st_t s_r, s_nxt;
   logic push, pop;

   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1)
         $error("FIFO depth must be a power of two of at least 2.");
   end

   assign in_ready = (s_r.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s_r.cnt != '0);
   assign out_data = s_r.mem[s_r.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.mem[s_r.wp] = in_data;
         s_nxt.wp = s_r.wp + AW'(1);
      end
      if (pop)
         s_nxt.rp = s_r.rp + AW'(1);
      if (push && !pop)
         s_nxt.cnt = s_r.cnt + (AW+1)'(1);
      else if (pop && !push)
         s_nxt.cnt = s_r.cnt - (AW+1)'(1);
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   fifo_no_overflow_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (s_r.cnt == (AW+1)'(DEPTH)) |-> !in_ready)
      else $error("FIFO accepted a word while full.");
endmodule

// [core/dscr_core.sv]
// Serial port logic of a 16-bit voltage output converter: shift chain, readback,
// update strobes, clear, power-down and power-on hold.
// Assumes all pins are asynchronous to clk_sys and the serial clock is far slower.
`timescale 1ns/10ps
`include "dscr_regs.svh"

// What this block does
// R1: Data out is last stage, pull-low only.
// R2: Power-down releases the data out pull-down.
// R3: Shift data in on falling edges, frame low.
// R4: Overflow bits ripple out on data out.
// R5: Host gives sixteen pulses per device.
// R6: Host sends farthest device's word first.
// R7: Frame high stops all shifting.
// R8: Host may run clock free or burst.
// R9: Update strobe loads converter register simultaneously.
// R10: Readback shows converter register on data out.
// R11: After sixteen edges data out echoes input.
// R12: Frame low, strobe high reads without update.
// R13: Readback data passes along the chain.
// R14: Power-on hold keeps output at ground.
// R15: Power-down input selects low power mode.
// R16: Power-up loads both registers with midscale.
// R17: Update on frame rise or strobe fall.
// R18: Power-down overrides, registers stay writable.
// R19: Clear zeroes output until next strobe.
// R20: Words travel most significant bit first.
module dscr_core
   import dscr_pkg::*;
#(
   parameter int POR_CYCLES = (`DSCR_POR_TIME_NS * 1000 + `DSCR_CLK_PERIOD_PS - 1)
                              / `DSCR_CLK_PERIOD_PS,
   parameter int FIFO_DEPTH = `DSCR_FIFO_DEPTH
) (
   // System clock and reset.
   input wire logic clk_sys,
   input wire logic nrst,
   // Serial port pins from the host.
   input wire logic serial_clk,
   input wire logic frame_sel_n,
   input wire logic serial_data_in,
   // Control pins.
   input wire logic load_update_n,
   input wire logic output_zero_n,
   input wire logic power_down_n,
   // Open-drain serial data out.
   input wire logic serial_data_out_i,
   output logic serial_data_out_o,
   output logic serial_data_out_oe,
   // Towards the analog core.
   output logic [`DSCR_WORD_BITS-1:0] dac_code,
   output logic analog_ground_level,
   output logic power_down_active
);
   localparam int PCB = `DSCR_POR_CNT_BITS;
   localparam logic [PCB-1:0] POR_INIT = PCB'(POR_CYCLES);
   localparam logic [4:0] FULL_WORD = 5'(`DSCR_WORD_BITS);

   initial begin
      if (POR_CYCLES < 1 || POR_CYCLES >= (1 << PCB))
         $error("POR_CYCLES does not fit the power-on counter.");
      if (FIFO_DEPTH < 2)
         $error("FIFO_DEPTH must be at least 2.");
   end

   // Each pin synchroniser: bit 0 first stage, bit 1 second stage, bit 2 previous.
   typedef struct packed {
      logic [2:0] sclk_s;
      logic [2:0] frm_s;
      logic [2:0] sdi_s;
      logic [2:0] load_update_n_s;
      logic [2:0] clr_s;
      logic [2:0] pd_s;
      dscr_frame_t frame;
      dscr_word_t shr;
      dscr_word_t in_reg;
      dscr_word_t dac;
      logic [4:0] cnt;
      logic load_update_n_seen;
      logic push_v;
      logic [`DSCR_WORD_BITS:0] push_d;
      logic zero_hold;
      logic [PCB-1:0] por_cnt;
      logic por_hold;
      logic sdo_lvl;
      logic sdo_oe;
      logic at_ground;
      logic pd_act;
   } dscr_state_t;

   dscr_state_t s_r, s_nxt;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [`DSCR_WORD_BITS:0] fifo_out_data;
   logic sclk_f, frm_f, frm_r, load_update_n_f;

   function automatic logic is_fall(input logic prev, input logic cur);
      is_fall = prev && !cur;
   endfunction

   assign sclk_f = is_fall(s_r.sclk_s[2], s_r.sclk_s[1]);
   assign frm_f = is_fall(s_r.frm_s[2], s_r.frm_s[1]);
   assign frm_r = is_fall(s_r.frm_s[1], s_r.frm_s[2]);
   assign load_update_n_f = is_fall(s_r.load_update_n_s[2], s_r.load_update_n_s[1]);
   // Completed words wait here; draining stalls during the power-on hold.
   assign fifo_out_ready = !s_r.por_hold;

   dscr_fifo #(
      .W(`DSCR_WORD_BITS + 1),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .in_valid(s_r.push_v),
      .in_ready(fifo_in_ready),
      .in_data(s_r.push_d),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   always_comb begin
      s_nxt = s_r;
      s_nxt.sclk_s = {s_r.sclk_s[1:0], serial_clk};
      s_nxt.frm_s = {s_r.frm_s[1:0], frame_sel_n};
      s_nxt.sdi_s = {s_r.sdi_s[1:0], serial_data_in};
      s_nxt.load_update_n_s = {s_r.load_update_n_s[1:0], load_update_n};
      s_nxt.clr_s = {s_r.clr_s[1:0], output_zero_n};
      s_nxt.pd_s = {s_r.pd_s[1:0], power_down_n};
      if (s_r.push_v && fifo_in_ready)
         s_nxt.push_v = 1'b0;
      case (s_r.frame)
         DSCR_FS_IDLE: begin
            if (frm_f) begin
               s_nxt.frame = DSCR_FS_SHIFT;
               s_nxt.cnt = '0;
               s_nxt.load_update_n_seen = 1'b0;
               // Readback: the converter register is parked in the shift stages.
               if (s_r.load_update_n_s[1])
                  s_nxt.shr = s_r.dac; // [R10] [R12]
            end
         end
         DSCR_FS_SHIFT: begin
            if (frm_r) begin
               s_nxt.frame = DSCR_FS_IDLE; // [R7]
               // Only a frame of at least one full word reaches the input register.
               if (s_r.cnt == FULL_WORD) begin
                  s_nxt.push_v = 1'b1;
                  s_nxt.push_d = {s_r.load_update_n_seen, s_r.shr}; // [R17]
               end
            end else if (sclk_f) begin
               // Oldest bit leaves at the top, so words move MSB first.
               s_nxt.shr = {s_r.shr[`DSCR_WORD_BITS-2:0], s_r.sdi_s[1]}; // [R3] [R4] [R20]
               if (s_r.cnt != FULL_WORD)
                  s_nxt.cnt = s_r.cnt + 5'h01;
               if (!s_r.load_update_n_s[1])
                  s_nxt.load_update_n_seen = 1'b1;
            end
         end
         default: s_nxt.frame = DSCR_FS_IDLE;
      endcase
      // Registers stay writable in power-down and while cleared.
      if (fifo_out_valid && fifo_out_ready) begin
         s_nxt.in_reg = fifo_out_data[`DSCR_WORD_BITS-1:0]; // [R18]
         if (fifo_out_data[`DSCR_WORD_BITS]) begin
            s_nxt.dac = fifo_out_data[`DSCR_WORD_BITS-1:0]; // [R17]
            s_nxt.zero_hold = 1'b0;
         end
      end
      // One shared strobe edge loads every chained device in the same cycle.
      if (load_update_n_f && s_r.frm_s[1]) begin
         s_nxt.dac = s_r.in_reg; // [R9] [R17]
         s_nxt.zero_hold = 1'b0; // [R19]
      end
      // Clear wins over any release in the same cycle.
      if (!s_r.clr_s[1])
         s_nxt.zero_hold = 1'b1; // [R19]
      if (s_r.por_cnt != '0)
         s_nxt.por_cnt = s_r.por_cnt - PCB'(1);
      s_nxt.por_hold = (s_nxt.por_cnt != '0); // [R14]
      s_nxt.pd_act = !s_r.pd_s[1]; // [R15]
      s_nxt.at_ground = s_nxt.por_hold || s_nxt.zero_hold || !s_r.pd_s[1]; // [R14] [R18]
      s_nxt.sdo_lvl = 1'b0; // [R1]
      // Pull low only for a zero in the last stage, and never in power-down.
      s_nxt.sdo_oe = !s_nxt.shr[`DSCR_WORD_BITS-1] && s_r.pd_s[1]; // [R1] [R2] [R11] [R13]
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s_r <= '0;
         s_r.sclk_s <= 3'h7;
         s_r.frm_s <= 3'h7;
         s_r.load_update_n_s <= 3'h7;
         s_r.clr_s <= 3'h7;
         s_r.pd_s <= 3'h7;
         s_r.frame <= DSCR_FS_IDLE;
         s_r.shr <= `DSCR_MIDSCALE; // [R16]
         s_r.in_reg <= `DSCR_MIDSCALE;
         s_r.dac <= `DSCR_MIDSCALE; // [R16]
         s_r.por_cnt <= POR_INIT;
         s_r.por_hold <= 1'b1;
         s_r.at_ground <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign serial_data_out_o = s_r.sdo_lvl;
   assign serial_data_out_oe = s_r.sdo_oe;
   assign dac_code = s_r.dac;
   assign analog_ground_level = s_r.at_ground;
   assign power_down_active = s_r.pd_act;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   sdo_pd_release_a: assert property ( // [R2]
      !s_r.pd_s[1] |=> !serial_data_out_oe)
      else $error("Data out pulled low during power-down.");

   sdo_last_stage_a: assert property ( // [R1]
      s_r.pd_s[1] |=> serial_data_out_oe == !s_r.shr[`DSCR_WORD_BITS-1])
      else $error("Data out does not follow the last shift stage.");

   shift_on_fall_a: assert property ( // [R3]
      (s_r.frame == DSCR_FS_SHIFT && sclk_f && !frm_r)
      |=> s_r.shr == {$past(s_r.shr[`DSCR_WORD_BITS-2:0]), $past(s_r.sdi_s[1])})
      else $error("Shift register missed a falling serial clock edge.");

   idle_no_shift_a: assert property ( // [R7]
      (s_r.frame == DSCR_FS_IDLE && !frm_f) |=> $stable(s_r.shr))
      else $error("Shift register moved while the frame was high.");

   readback_load_a: assert property ( // [R12]
      (s_r.frame == DSCR_FS_IDLE && frm_f && s_r.load_update_n_s[1])
      |=> s_r.shr == $past(s_r.dac) ##1 $stable(s_r.dac))
      else $error("Readback did not load the converter register.");

   async_update_a: assert property ( // [R9]
      (load_update_n_f && s_r.frm_s[1] && !(fifo_out_valid && fifo_out_ready))
      |=> dac_code == $past(s_r.in_reg))
      else $error("Strobe edge did not update the converter register.");

   clear_zero_a: assert property ( // [R19]
      !s_r.clr_s[1] |=> analog_ground_level [*2])
      else $error("Clear did not hold the output at zero.");

   pd_ground_a: assert property ( // [R18]
      !s_r.pd_s[1] |=> analog_ground_level && power_down_active)
      else $error("Power-down did not force the output to ground.");

   por_hold_a: assert property ( // [R14]
      s_r.por_hold |-> analog_ground_level)
      else $error("Output left ground during the power-on hold.");

   word_push_a: assert property ( // [R17]
      (s_r.frame == DSCR_FS_SHIFT && frm_r && s_r.cnt == FULL_WORD)
      |=> s_r.push_v && s_r.push_d[`DSCR_WORD_BITS-1:0] == $past(s_r.shr))
      else $error("A complete word was not queued at frame end.");

   sdo_drive_low_a: assert property ( // [R1]
      !serial_data_out_o)
      else $error("Data out drove a high level.");

   cnt_saturate_a: assert property ( // [R4]
      s_r.cnt <= FULL_WORD)
      else $error("Shift counter ran past one word.");

   frame_start_a: assert property ( // [R3]
      (s_r.frame == DSCR_FS_IDLE && frm_f)
      |=> s_r.frame == DSCR_FS_SHIFT && s_r.cnt == '0)
      else $error("Frame start did not open a shift frame.");

   frame_end_a: assert property ( // [R7]
      (s_r.frame == DSCR_FS_SHIFT && frm_r) |=> s_r.frame == DSCR_FS_IDLE)
      else $error("Frame end did not stop shifting.");

   zero_hold_keep_a: assert property ( // [R19]
      (s_r.zero_hold && !(load_update_n_f && s_r.frm_s[1])
       && !(fifo_out_valid && fifo_out_ready && fifo_out_data[`DSCR_WORD_BITS]))
      |=> s_r.zero_hold)
      else $error("Clear hold ended without a strobe.");

   pd_release_a: assert property ( // [R15]
      s_r.pd_s[1] |=> !power_down_active)
      else $error("Low power mode stayed on after release.");

   sync_update_a: assert property ( // [R17]
      (fifo_out_valid && fifo_out_ready && fifo_out_data[`DSCR_WORD_BITS]
       && !(load_update_n_f && s_r.frm_s[1]))
      |=> dac_code == $past(fifo_out_data[`DSCR_WORD_BITS-1:0]))
      else $error("Synchronous word did not reach the converter register.");

   in_reg_load_a: assert property ( // [R18]
      (fifo_out_valid && fifo_out_ready)
      |=> s_r.in_reg == $past(fifo_out_data[`DSCR_WORD_BITS-1:0]))
      else $error("Completed word did not reach the input register.");

   por_once_a: assert property ( // [R14]
      !s_r.por_hold |=> !s_r.por_hold)
      else $error("Power-on hold came back without a reset.");
endmodule

// [test/dscr_host_model.sv]
// Host serial master model: drives frame select, serial clock and serial data.
// Assumes the device data output line is pulled up and fed back as sdo_line.
`timescale 1ns/10ps
module dscr_host_model #(
   parameter real HALF_NS = 32.0
) (
   // Serial pins towards the device.
   output logic serial_clk,
   output logic frame_sel_n,
   output logic serial_data_in,
   // Pulled-up data output line.
   input wire logic sdo_line
);
   // The clock idles high; between frames it moves only when stray pulses it.
   initial begin
      serial_clk = 1'b1;
      frame_sel_n = 1'b1;
      serial_data_in = 1'b0;
   end

   // One frame of exactly 32 falls, a chain of two; the far word goes first.
   task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
      frame_sel_n = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         serial_data_in = tx[i];
         #(HALF_NS);
         rx[i] = sdo_line;
         serial_clk = 1'b0;
         #(HALF_NS);
         serial_clk = 1'b1;
      end
      frame_sel_n = 1'b1;
      // The released data line must not keep showing the last bit.
      serial_data_in = ~tx[0];
      #(HALF_NS);
   endtask

   // Clock pulses with the frame high, which the device must ignore.
   task automatic stray(input int n);
      for (int i = 0; i < n; i++) begin
         #(HALF_NS) serial_clk = 1'b0;
         #(HALF_NS) serial_clk = 1'b1;
      end
   endtask
endmodule

// [test/tb_dac_serial_chain_readback.sv]
// Self-checking bench of the serial chain and readback block.
// Assumes dscr_core with a short power-on hold and the host model beside it.
`timescale 1ns/10ps
module tb_dac_serial_chain_readback;
   localparam int POR_CYC = 4;
   localparam int LIMIT = 20000;
   typedef struct {logic sync; logic [31:0] tx;} dscr_row_t;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic load_update_n = 1'b1;
   logic output_zero_n = 1'b1;
   logic power_down_n = 1'b1;
   logic serial_clk, frame_sel_n, serial_data_in;
   logic sdo_o, sdo_oe, sdo_line, agl, pda;
   logic [15:0] dac_code, dac_exp, shr_exp, exp_rb;
   logic [31:0] rx;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   dscr_row_t rows[4] = '{'{1'b0, 32'h1234A5C3}, '{1'b1, 32'h80017FFE},
                          '{1'b0, 32'hFFFF0000}, '{1'b1, 32'h0000FFFF}};

   always #2.5 clk_sys = ~clk_sys;
   assign sdo_line = sdo_oe ? sdo_o : 1'b1;

   dscr_core #(.POR_CYCLES(POR_CYC), .FIFO_DEPTH(8)) dut_u (
      .clk_sys(clk_sys), .nrst(nrst), .serial_clk(serial_clk), .frame_sel_n(frame_sel_n),
      .serial_data_in(serial_data_in), .load_update_n(load_update_n),
      .output_zero_n(output_zero_n), .power_down_n(power_down_n),
      .serial_data_out_i(sdo_line), .serial_data_out_o(sdo_o), .serial_data_out_oe(sdo_oe),
      .dac_code(dac_code), .analog_ground_level(agl), .power_down_active(pda));

   dscr_host_model host_u (.serial_clk(serial_clk), .frame_sel_n(frame_sel_n),
      .serial_data_in(serial_data_in), .sdo_line(sdo_line));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      if (miscompares == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // Asynchronous update: a short low pulse on the strobe with the frame high.
   task automatic strobe();
      @(negedge clk_sys) load_update_n = 1'b0;
      idle(4);
      load_update_n = 1'b1;
      idle(6);
   endtask

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         miscompares++;
         conclude();
      end
   end

   initial begin
      dac_exp = 16'h8000;
      shr_exp = 16'h8000;
      idle(5);
      check({pda, agl, sdo_oe, sdo_o, dac_code}, {4'b0100, 16'h8000});
      nrst = 1'b1;
      idle(2);
      check(agl, 1'b1);
      idle(POR_CYC + 4);
      check(agl, 1'b0);
      foreach (rows[k]) begin
         @(negedge clk_sys) load_update_n = ~rows[k].sync;
         exp_rb = rows[k].sync ? shr_exp : dac_exp;
         host_u.xfer(rows[k].tx, rx);
         check(rx, {exp_rb, rows[k].tx[31:16]});
         idle(10);
         if (!rows[k].sync) begin
            check(dac_code, dac_exp);
            strobe();
         end
         load_update_n = 1'b1;
         dac_exp = rows[k].tx[15:0];
         shr_exp = rows[k].tx[15:0];
         check(dac_code, dac_exp);
      end
      power_down_n = 1'b0;
      idle(6);
      check({pda, agl, sdo_oe, sdo_o}, 4'b1100);
      load_update_n = 1'b0;
      host_u.xfer(32'hAAAA1357, rx);
      check(rx, 32'hFFFFFFFF);
      idle(10);
      load_update_n = 1'b1;
      check({agl, dac_code}, {1'b1, 16'h1357});
      power_down_n = 1'b1;
      idle(6);
      check({pda, agl}, 2'b00);
      output_zero_n = 1'b0;
      idle(6);
      check(agl, 1'b1);
      output_zero_n = 1'b1;
      idle(6);
      check(agl, 1'b1);
      strobe();
      check({agl, dac_code}, {1'b0, 16'h1357});
      host_u.stray(5);
      idle(6);
      strobe();
      check(dac_code, 16'h1357);
      host_u.xfer(32'h0F0F3C3C, rx);
      check(rx, 32'h13570F0F);
      idle(4);
      nrst = 1'b0;
      idle(2);
      check({agl, dac_code}, {1'b1, 16'h8000});
      nrst = 1'b1;
      idle(2);
      check({agl, sdo_oe}, 2'b10);
      conclude();
   end
endmodule
